// *** inc/spt_regs.svh ***
// register offsets, field positions, reset values and timing figures
// assumes a byte address on an 8-bit register port with 32-bit words
`ifndef SPT_REGS_SVH
`define SPT_REGS_SVH

`define SPT_OFF_CTRL       8'h00
`define SPT_OFF_START_CARE 8'h04
`define SPT_OFF_START_LVL  8'h08
`define SPT_OFF_END_CARE   8'h0c
`define SPT_OFF_END_LVL    8'h10
`define SPT_OFF_LIMIT_MIN  8'h14
`define SPT_OFF_LIMIT_MAX  8'h18
`define SPT_OFF_HOLDOFF    8'h1c
`define SPT_OFF_AUTO_WAIT  8'h20
`define SPT_OFF_STATUS     8'h24
`define SPT_OFF_INTERVAL   8'h28

`define SPT_CTRL_EN        0
`define SPT_CTRL_AUTO      1
`define SPT_CTRL_DLY       2
`define SPT_CTRL_QUAL      4
`define SPT_CTRL_SFUNC     8
`define SPT_CTRL_EFUNC     12
`define SPT_STAT_SEEN      4
`define SPT_STAT_FORCED    5

`define SPT_RST_LIMIT      32'h0000_0000
`define SPT_CLK_MHZ        100
`define SPT_HOLDOFF_NS     160
`define SPT_AUTO_WAIT_US   1000

`endif

// *** inc/spt_pkg.sv ***
// types shared by the sequence pattern trigger
// assumes spt_regs.svh carries the numeric constants
package spt_pkg;

	typedef enum logic [1:0] {SPT_AND, SPT_NAND, SPT_OR, SPT_NOR} spt_func_t;

	typedef enum logic [2:0] {SPT_LT, SPT_GT, SPT_TOUT, SPT_IN, SPT_OUT} spt_qual_t;

	typedef enum logic [1:0] {SPT_HOLD, SPT_ARMED, SPT_TIMING} spt_state_t;

	typedef struct packed {
		logic [16:0] care;
		logic [16:0] lvl;
	} spt_pat_t;

	typedef struct packed {
		logic        en;
		logic        auto_mode;
		logic        dly_sel;
		spt_qual_t   qual;
		spt_func_t   sfunc;
		spt_func_t   efunc;
		spt_pat_t    spat;
		spt_pat_t    epat;
		logic [31:0] tmin;
		logic [31:0] tmax;
		logic [31:0] hold;
		logic [31:0] auto_wait;
	} spt_cfg_t;

	typedef struct packed {
		spt_cfg_t    cfg;
		spt_state_t  state;
		logic [31:0] hcnt;
		logic [31:0] tcnt;
		logic [31:0] acnt;
		logic [31:0] last_int;
		logic [31:0] rdata;
		logic        start_prev;
		logic        trig_main;
		logic        trig_dly;
		logic        acq;
		logic        seen;
		logic        forced;
	} spt_st_t;

endpackage

// *** src/spt_trigger.sv ***
// two-step pattern sequence trigger with time qualification
// assumes probe inputs already thresholded and synchronous to CLK
//
// Functional notes
// - after holdoff, watch all sixteen channels plus auxiliary input
// - per-input expected high, low or don't care; don't care excluded
// - start pattern true starts the interval timer at once
// - timer running: compare same inputs against separate end pattern
// - end pattern true is recognised and stops the timer that cycle
// - trigger only when the selected time qualifier is satisfied
// - AND: true when every considered input matches
// - NAND: true when any considered input mismatches
// - OR: true when any considered input matches
// - NOR: true when every considered input mismatches
// - shorter-than: end before limit; longer-than: end after limit
// - timeout: qualifies when end not true before limit elapses
// - in range: end after minimum and before maximum
// - outside range: end before minimum or after maximum
// - all qualifiers but timeout trigger when end becomes true
// - timeout triggers when timer reaches limit, no end needed
// - interval measured from the start pattern becoming true
// - start pattern ignored while timer runs
// - same engine serves main and delayed trigger systems
// - an all don't care pattern is never recognised
// - start and end patterns have independent logic functions
// - start and end patterns share one set of input thresholds
// - normal acquires only on trigger; auto forces after wait
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "spt_regs.svh"

module spt_trigger #(
	parameter logic [31:0] HOLD_CYC = 32'(`SPT_HOLDOFF_NS * `SPT_CLK_MHZ / 1000),
	parameter logic [31:0] AUTO_CYC = 32'(`SPT_AUTO_WAIT_US * `SPT_CLK_MHZ)
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST,
	// register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [31:0] REG_RDATA,
	// probed inputs
	input  wire logic [15:0] CH,
	input  wire logic        AUX,
	// trigger outputs
	output logic             TRIG_MAIN,
	output logic             TRIG_DLY,
	output logic             ACQ,
	output logic             ARMED
);

	spt_pkg::spt_st_t q;
	spt_pkg::spt_st_t d;

	logic [16:0] probe;
	logic        start_now;
	logic        end_now;
	logic        start_edge;
	logic        any_trig;

	// true when the probe vector satisfies a pattern under a function
	function automatic logic pat_true(
		input logic [16:0]        in,
		input spt_pkg::spt_pat_t  p,
		input spt_pkg::spt_func_t f
	);
		logic [16:0] hit;
		logic        r;
		hit = ~(in ^ p.lvl) & p.care;
		unique case (f)
			spt_pkg::SPT_AND:  r = (hit == p.care);
			spt_pkg::SPT_NAND: r = (hit != p.care);
			spt_pkg::SPT_OR:   r = |hit;
			spt_pkg::SPT_NOR:  r = ~|hit;
		endcase
		return r & (|p.care);
	endfunction

	// one thresholded vector feeds both patterns
	assign probe = {AUX, CH};

	assign start_now = pat_true(probe, q.cfg.spat, q.cfg.sfunc);
	assign end_now = pat_true(probe, q.cfg.epat, q.cfg.efunc);

	// a pattern already true at arming must drop first
	assign start_edge = start_now & ~q.start_prev;

	assign any_trig = q.trig_main | q.trig_dly;

	always_comb begin
		logic fire;
		logic fail;
		logic done;
		fire = 1'b0;
		fail = 1'b0;
		done = 1'b0;
		d = q;
		d.trig_main = 1'b0;
		d.trig_dly = 1'b0;
		d.acq = 1'b0;
		d.rdata = 32'h0;
		d.start_prev = start_now;

		if (REG_WR) begin
			unique case (REG_ADDR)
				`SPT_OFF_CTRL: begin
					d.cfg.en = REG_WDATA[`SPT_CTRL_EN];
					d.cfg.auto_mode = REG_WDATA[`SPT_CTRL_AUTO];
					d.cfg.dly_sel = REG_WDATA[`SPT_CTRL_DLY];
					d.cfg.qual = spt_pkg::spt_qual_t'(REG_WDATA[`SPT_CTRL_QUAL +: 3]);
					d.cfg.sfunc = spt_pkg::spt_func_t'(REG_WDATA[`SPT_CTRL_SFUNC +: 2]);
					d.cfg.efunc = spt_pkg::spt_func_t'(REG_WDATA[`SPT_CTRL_EFUNC +: 2]);
				end
				`SPT_OFF_START_CARE: begin
					d.cfg.spat.care = REG_WDATA[16:0];
				end
				`SPT_OFF_START_LVL: begin
					d.cfg.spat.lvl = REG_WDATA[16:0];
				end
				`SPT_OFF_END_CARE: begin
					d.cfg.epat.care = REG_WDATA[16:0];
				end
				`SPT_OFF_END_LVL: begin
					d.cfg.epat.lvl = REG_WDATA[16:0];
				end
				`SPT_OFF_LIMIT_MIN: begin
					d.cfg.tmin = REG_WDATA;
				end
				`SPT_OFF_LIMIT_MAX: begin
					d.cfg.tmax = REG_WDATA;
				end
				`SPT_OFF_HOLDOFF: begin
					d.cfg.hold = REG_WDATA;
				end
				`SPT_OFF_AUTO_WAIT: begin
					d.cfg.auto_wait = REG_WDATA;
				end
				`SPT_OFF_STATUS: begin
					// write one to clear; hardware set below wins
					if (REG_WDATA[`SPT_STAT_SEEN]) begin
						d.seen = 1'b0;
					end
					if (REG_WDATA[`SPT_STAT_FORCED]) begin
						d.forced = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		unique case (q.state)
			spt_pkg::SPT_HOLD: begin
				d.acnt = 32'h0;
				if (!q.cfg.en) begin
					d.hcnt = 32'h0;
				end else if (q.hcnt >= q.cfg.hold) begin
					d.state = spt_pkg::SPT_ARMED;
				end else begin
					d.hcnt = q.hcnt + 32'h1;
				end
			end
			spt_pkg::SPT_ARMED: begin
				if (start_edge) begin
					d.state = spt_pkg::SPT_TIMING;
					d.tcnt = 32'h1;
				end
			end
			spt_pkg::SPT_TIMING: begin
				// start_now is not looked at here
				if (q.tcnt != 32'hffff_ffff) begin
					d.tcnt = q.tcnt + 32'h1;
				end
				unique case (q.cfg.qual)
					spt_pkg::SPT_LT: begin
						if (end_now) begin
							fire = q.tcnt < q.cfg.tmin;
							fail = !fire;
						end else begin
							fail = q.tcnt >= q.cfg.tmin;
						end
					end
					spt_pkg::SPT_GT: begin
						fire = end_now && q.tcnt > q.cfg.tmin;
						fail = end_now && !fire;
					end
					spt_pkg::SPT_TOUT: begin
						// expiry in the same cycle as an end match still fires
						fire = q.tcnt >= q.cfg.tmin;
						fail = end_now && !fire;
					end
					spt_pkg::SPT_IN: begin
						if (end_now) begin
							fire = q.tcnt > q.cfg.tmin && q.tcnt < q.cfg.tmax;
							fail = !fire;
						end else begin
							fail = q.tcnt >= q.cfg.tmax;
						end
					end
					spt_pkg::SPT_OUT: begin
						fire = end_now && (q.tcnt < q.cfg.tmin || q.tcnt > q.cfg.tmax);
						fail = end_now && !fire;
					end
					default: begin
						fail = 1'b1;
					end
				endcase
				if (end_now) begin
					d.last_int = q.tcnt;
				end
				if (fire) begin
					d.state = spt_pkg::SPT_HOLD;
					d.hcnt = 32'h0;
					d.trig_main = !q.cfg.dly_sel;
					d.trig_dly = q.cfg.dly_sel;
					d.acq = 1'b1;
					d.seen = 1'b1;
					done = 1'b1;
				end else if (fail || end_now) begin
					d.state = spt_pkg::SPT_ARMED;
					d.tcnt = 32'h0;
				end
			end
			default: begin
				d.state = spt_pkg::SPT_HOLD;
			end
		endcase

		// auto mode forces an acquisition after its wait
		if (q.state != spt_pkg::SPT_HOLD && !done) begin
			if (!q.cfg.en) begin
				d.state = spt_pkg::SPT_HOLD;
				d.hcnt = 32'h0;
			end else if (q.cfg.auto_mode && q.acnt >= q.cfg.auto_wait) begin
				d.state = spt_pkg::SPT_HOLD;
				d.hcnt = 32'h0;
				d.acq = 1'b1;
				d.forced = 1'b1;
			end else begin
				d.acnt = q.acnt + 32'h1;
			end
		end

		if (REG_RD) begin
			unique case (REG_ADDR)
				`SPT_OFF_CTRL: begin
					d.rdata = {18'h0, q.cfg.efunc, 2'h0, q.cfg.sfunc, 1'b0,
						q.cfg.qual, 1'b0, q.cfg.dly_sel, q.cfg.auto_mode, q.cfg.en};
				end
				`SPT_OFF_START_CARE: begin
					d.rdata = {15'h0, q.cfg.spat.care};
				end
				`SPT_OFF_START_LVL: begin
					d.rdata = {15'h0, q.cfg.spat.lvl};
				end
				`SPT_OFF_END_CARE: begin
					d.rdata = {15'h0, q.cfg.epat.care};
				end
				`SPT_OFF_END_LVL: begin
					d.rdata = {15'h0, q.cfg.epat.lvl};
				end
				`SPT_OFF_LIMIT_MIN: begin
					d.rdata = q.cfg.tmin;
				end
				`SPT_OFF_LIMIT_MAX: begin
					d.rdata = q.cfg.tmax;
				end
				`SPT_OFF_HOLDOFF: begin
					d.rdata = q.cfg.hold;
				end
				`SPT_OFF_AUTO_WAIT: begin
					d.rdata = q.cfg.auto_wait;
				end
				`SPT_OFF_STATUS: begin
					d.rdata = {26'h0, q.forced, q.seen, 2'h0, q.state};
				end
				`SPT_OFF_INTERVAL: begin
					d.rdata = q.last_int;
				end
				default: begin
					d.rdata = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.cfg.tmin <= `SPT_RST_LIMIT;
			q.cfg.tmax <= `SPT_RST_LIMIT;
			q.cfg.hold <= HOLD_CYC;
			q.cfg.auto_wait <= AUTO_CYC;
			q.start_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign REG_RDATA = q.rdata;
	assign TRIG_MAIN = q.trig_main;
	assign TRIG_DLY = q.trig_dly;
	assign ACQ = q.acq;
	assign ARMED = (q.state != spt_pkg::SPT_HOLD);

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence s_start;
		q.state == spt_pkg::SPT_ARMED && start_edge && q.cfg.en
			&& !(q.cfg.auto_mode && q.acnt >= q.cfg.auto_wait);
	endsequence

	sequence s_timing;
		q.state == spt_pkg::SPT_TIMING && q.tcnt == 32'h1;
	endsequence

	property p_start_runs;
		s_start |=> s_timing;
	endproperty

	chk_hold_gate: assert property (
		q.state == spt_pkg::SPT_HOLD && q.hcnt < q.cfg.hold |=> q.state == spt_pkg::SPT_HOLD
	) else $error("left holdoff before its count");

	chk_start_timer: assert property (p_start_runs)
		else $error("start edge did not start the timer at one");

	chk_all_dc: assert property (
		q.state == spt_pkg::SPT_ARMED && q.cfg.spat.care == 17'h0 |=> q.state != spt_pkg::SPT_TIMING
	) else $error("all don't care start pattern was recognised");

	chk_end_stop: assert property (
		q.state == spt_pkg::SPT_TIMING && end_now && q.cfg.en |=>
			q.state != spt_pkg::SPT_TIMING && q.last_int == $past(q.tcnt)
	) else $error("end match did not stop the timer");

	chk_trig_source: assert property (
		any_trig |-> $past(q.state) == spt_pkg::SPT_TIMING && $past(q.tcnt) != 32'h0
	) else $error("trigger without a timed sequence");

	chk_lt_window: assert property (
		q.state == spt_pkg::SPT_TIMING && q.cfg.qual == spt_pkg::SPT_LT && q.cfg.en
			&& end_now && q.tcnt < q.cfg.tmin |=> any_trig ##1 !any_trig
	) else $error("shorter-than end match did not trigger once");

	chk_timeout_fire: assert property (
		q.state == spt_pkg::SPT_TIMING && q.cfg.qual == spt_pkg::SPT_TOUT && q.cfg.en
			&& q.tcnt >= q.cfg.tmin |=> any_trig && ACQ
	) else $error("timeout did not trigger at expiry");

	chk_fail_rearm: assert property (
		q.state == spt_pkg::SPT_TIMING && q.cfg.qual == spt_pkg::SPT_GT && q.cfg.en
			&& end_now && q.tcnt <= q.cfg.tmin && !(q.cfg.auto_mode && q.acnt >= q.cfg.auto_wait)
			|=> q.state == spt_pkg::SPT_ARMED && !any_trig
	) else $error("failed attempt did not return to start watch");

	chk_in_range: assert property (
		q.state == spt_pkg::SPT_TIMING && q.cfg.qual == spt_pkg::SPT_IN && q.cfg.en && end_now
			&& q.tcnt > q.cfg.tmin && q.tcnt < q.cfg.tmax |=> any_trig
	) else $error("in range end match did not trigger");

	chk_route: assert property (
		any_trig |-> (TRIG_DLY == $past(q.cfg.dly_sel)) && (TRIG_MAIN != TRIG_DLY)
	) else $error("trigger routed to the wrong system");

	chk_normal_acq: assert property (
		ACQ && !q.forced |-> any_trig
	) else $error("normal mode acquired without a trigger");

endmodule
`default_nettype wire

// *** tb/spt_probe.sv ***
// probe model: drives the sixteen channels and the auxiliary input
// assumes the bench calls set right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module spt_probe (
	// probed levels, aux is bit 16 of a pattern
	output logic [15:0] ch,
	output logic        aux
);
	logic [16:0] lvl_q = 17'h0;

	assign {aux, ch} = lvl_q;

	// levels move only on command, like thresholded probes
	task automatic set(input logic [16:0] v);
		lvl_q <= v;
	endtask
endmodule

`default_nettype wire

// *** tb/sequence_pattern_trigger_test.sv ***
// self-checking bench for the sequence pattern trigger
// assumes spt_pkg compiled first and spt_regs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "spt_regs.svh"

module sequence_pattern_trigger_test;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'h0;
	logic        rd = 1'h0;
	logic [31:0] rdata;
	logic [15:0] ch;
	logic        aux;
	logic        trig_main;
	logic        trig_dly;
	logic        acq;
	logic        armed;
	logic        tm;
	logic        td;
	logic        aq;
	int          fail_count = 0;
	int          num_checks = 0;

	always #5 clk = ~clk;

	// short holdoff and auto wait keep the run brief
	spt_trigger #(.HOLD_CYC(32'h4), .AUTO_CYC(32'h32)) i_spt_trigger (
		.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CH(ch), .AUX(aux),
		.TRIG_MAIN(trig_main), .TRIG_DLY(trig_dly), .ACQ(acq), .ARMED(armed)
	);

	spt_probe i_spt_probe (.ch(ch), .aux(aux));

	task automatic chk(input string name, input logic [31:0] exp, got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chkb(input string name, input logic exp, got);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, exp);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		chk(name, exp, rdata & m);
	endtask

	task automatic ctl(input spt_pkg::spt_qual_t q, input spt_pkg::spt_func_t sf, ef,
			input logic dly, au);
		wr_reg(`SPT_OFF_CTRL, {18'h0, ef, 2'h0, sf, 1'h0, q, 1'h0, dly, au, 1'h1});
	endtask

	// idle drops the start pattern so that val gives a fresh start edge
	task automatic run(input logic [16:0] idle, val, e, input int n, w);
		int k;
		tm = 1'h0;
		td = 1'h0;
		aq = 1'h0;
		i_spt_probe.set(idle);
		k = 0;
		while (armed !== 1'h1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		repeat (2) @(posedge clk);
		i_spt_probe.set(val);
		if (n > 0) begin
			repeat (n) @(posedge clk);
			i_spt_probe.set(val | e);
		end
		repeat (w) begin
			@(posedge clk);
			#1;
			tm |= trig_main;
			td |= trig_dly;
			aq |= acq;
		end
	endtask

	// start on ch1 high, end when ch2 leaves low; end seen n cycles after start
	task automatic qual_case(input spt_pkg::spt_qual_t q, input int n, input logic exp);
		ctl(q, spt_pkg::SPT_AND, spt_pkg::SPT_NOR, 1'h0, 1'h0);
		run(17'h0, 17'h1, 17'h2, n, 24);
		chkb("trig_main", exp, tm);
		chkb("acq", exp, aq);
		if (exp && n > 0) begin
			rd_chk("interval", `SPT_OFF_INTERVAL, 32'hffff_ffff, 32'(n));
		end
	endtask

	// start pattern on ch1 and aux, timeout fires once a start is seen
	task automatic fn_case(input spt_pkg::spt_func_t f, input logic [16:0] care,
			input logic [1:0] i, v, input logic exp);
		wr_reg(`SPT_OFF_CTRL, 32'h0);
		wr_reg(`SPT_OFF_START_CARE, {15'h0, care});
		i_spt_probe.set({i[1], 15'h0, i[0]});
		ctl(spt_pkg::SPT_TOUT, f, spt_pkg::SPT_AND, 1'h0, 1'h0);
		run({i[1], 15'h0, i[0]}, {v[1], 15'h0, v[0]}, 17'h0, 0, 24);
		chkb("start_match", exp, tm);
	endtask

	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd_chk("ctrl", `SPT_OFF_CTRL, 32'hffff_ffff, 32'h0);
		rd_chk("holdoff", `SPT_OFF_HOLDOFF, 32'hffff_ffff, 32'h4);
		rd_chk("auto_wait", `SPT_OFF_AUTO_WAIT, 32'hffff_ffff, 32'h32);
		rd_chk("limit_min", `SPT_OFF_LIMIT_MIN, 32'hffff_ffff, 32'h0);
		wr_reg(8'h2c, 32'hffff_ffff);
		rd_chk("unmapped", 8'h2c, 32'hffff_ffff, 32'h0);
		// all don't care start pattern here, so arming cannot start a sequence
		ctl(spt_pkg::SPT_LT, spt_pkg::SPT_AND, spt_pkg::SPT_AND, 1'h0, 1'h0);
		repeat (4) @(posedge clk);
		#1;
		chkb("armed_hold", 1'h0, armed);
		@(posedge clk);
		#1;
		chkb("armed", 1'h1, armed);
		wr_reg(`SPT_OFF_CTRL, 32'h0);
		$display("test registers done");
		wr_reg(`SPT_OFF_START_CARE, 32'h1);
		wr_reg(`SPT_OFF_START_LVL, 32'h1);
		wr_reg(`SPT_OFF_END_CARE, 32'h2);
		wr_reg(`SPT_OFF_END_LVL, 32'h0);
		wr_reg(`SPT_OFF_LIMIT_MIN, 32'h5);
		wr_reg(`SPT_OFF_LIMIT_MAX, 32'ha);
		qual_case(spt_pkg::SPT_LT, 3, 1'h1);
		qual_case(spt_pkg::SPT_LT, 7, 1'h0);
		qual_case(spt_pkg::SPT_GT, 7, 1'h1);
		qual_case(spt_pkg::SPT_GT, 3, 1'h0);
		qual_case(spt_pkg::SPT_TOUT, 0, 1'h1);
		qual_case(spt_pkg::SPT_TOUT, 3, 1'h0);
		qual_case(spt_pkg::SPT_IN, 7, 1'h1);
		qual_case(spt_pkg::SPT_IN, 3, 1'h0);
		qual_case(spt_pkg::SPT_IN, 12, 1'h0);
		qual_case(spt_pkg::SPT_OUT, 3, 1'h1);
		qual_case(spt_pkg::SPT_OUT, 12, 1'h1);
		qual_case(spt_pkg::SPT_OUT, 7, 1'h0);
		qual_case(spt_pkg::spt_qual_t'(3'h5), 3, 1'h0);
		$display("test qualifiers done");
		ctl(spt_pkg::SPT_LT, spt_pkg::SPT_AND, spt_pkg::SPT_NOR, 1'h1, 1'h0);
		run(17'h0, 17'h1, 17'h2, 3, 24);
		chkb("trig_dly", 1'h1, td);
		chkb("trig_main", 1'h0, tm);
		rd_chk("status", `SPT_OFF_STATUS, 32'h33, 32'h11);
		wr_reg(`SPT_OFF_STATUS, 32'h10);
		rd_chk("seen_clr", `SPT_OFF_STATUS, 32'h10, 32'h0);
		$display("test delayed done");
		wr_reg(`SPT_OFF_START_LVL, 32'h1_0001);
		wr_reg(`SPT_OFF_END_CARE, 32'h0);
		wr_reg(`SPT_OFF_LIMIT_MIN, 32'h3);
		fn_case(spt_pkg::SPT_AND, 17'h10001, 2'h0, 2'h3, 1'h1);
		fn_case(spt_pkg::SPT_AND, 17'h10001, 2'h0, 2'h2, 1'h0);
		fn_case(spt_pkg::SPT_NAND, 17'h10001, 2'h3, 2'h2, 1'h1);
		fn_case(spt_pkg::SPT_NAND, 17'h10001, 2'h3, 2'h3, 1'h0);
		fn_case(spt_pkg::SPT_OR, 17'h10001, 2'h0, 2'h2, 1'h1);
		fn_case(spt_pkg::SPT_OR, 17'h10001, 2'h0, 2'h0, 1'h0);
		fn_case(spt_pkg::SPT_NOR, 17'h10001, 2'h3, 2'h0, 1'h1);
		fn_case(spt_pkg::SPT_NOR, 17'h10001, 2'h3, 2'h1, 1'h0);
		fn_case(spt_pkg::SPT_AND, 17'h0, 2'h0, 2'h3, 1'h0);
		$display("test functions done");
		ctl(spt_pkg::SPT_LT, spt_pkg::SPT_AND, spt_pkg::SPT_AND, 1'h0, 1'h1);
		run(17'h0, 17'h0, 17'h0, 0, 80);
		chkb("acq", 1'h1, aq);
		chkb("trig_main", 1'h0, tm);
		wr_reg(`SPT_OFF_CTRL, 32'h0);
		rd_chk("forced", `SPT_OFF_STATUS, 32'h20, 32'h20);
		wr_reg(`SPT_OFF_STATUS, 32'h20);
		rd_chk("forced_clr", `SPT_OFF_STATUS, 32'h20, 32'h0);
		$display("test auto done");
		end_of_test;
	end

	// whole run needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_of_test;
	end
endmodule

`default_nettype wire
